// ===== eee_defines.vh
// Constants for the energy-saving transmit hold control block.
// Assumes a 200 MHz core clock; included by bare name.
`ifndef EEE_DEFINES_VH
`define EEE_DEFINES_VH

`define EEE_CLK_PERIOD_PS   5000
`define EEE_NPORTS          10
`define EEE_NQUEUES         8

// Wakeup times in ns, cycles rounded up (least times)
`define EEE_WAKE_1G_NS      17000
`define EEE_WAKE_OTHER_NS   30000
`define EEE_WAKE_1G_CYC     ((`EEE_WAKE_1G_NS * 1000 + `EEE_CLK_PERIOD_PS - 1) / `EEE_CLK_PERIOD_PS)
`define EEE_WAKE_OTHER_CYC  ((`EEE_WAKE_OTHER_NS * 1000 + `EEE_CLK_PERIOD_PS - 1) / `EEE_CLK_PERIOD_PS)

// Hold time in ns, cycles rounded down (longest time)
`define EEE_HOLD_NS         48000
`define EEE_HOLD_CYC        ((`EEE_HOLD_NS * 1000) / `EEE_CLK_PERIOD_PS)

`define EEE_BYTE_THRESH     16'd3000

// Register byte addresses
`define EEE_REG_ENABLE      8'h00
`define EEE_REG_POWERED     8'h04
`define EEE_REG_ALLOW       8'h08
`define EEE_REG_URGENT0     8'h10
`define EEE_REG_URGENT_LAST 8'h34

// Reset values
`define EEE_ENABLE_RST      10'h000
`define EEE_URGENT_RST      80'h0

`endif

// ===== eee_reg_slave.v
// Register slave for the energy-saving control: enable, urgent masks, status.
// Assumes a one-cycle strobe master; read data valid only the cycle after.
`timescale 1ns/1ps
`default_nettype none
`include "eee_defines.vh"

module eee_reg_slave (
  input  wire        i_clk,
  input  wire        i_nrst,
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  input  wire [9:0]  i_powered,
  input  wire [9:0]  i_allow,
  output reg  [31:0] o_rdata,
  output reg  [9:0]  o_enable,
  output reg  [79:0] o_urgent
);

  // Urgent register index from byte address; 4'hf when not an urgent register
  function [3:0] urg_idx;
    input [7:0] a;
    begin
      if (a >= `EEE_REG_URGENT0 && a <= `EEE_REG_URGENT_LAST && a[1:0] == 2'b00)
        urg_idx = a[5:2] - 4'h4;
      else
        urg_idx = 4'hf;
    end
  endfunction

  wire [3:0] wr_idx = urg_idx(i_addr);
  integer    p;

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_enable <= `EEE_ENABLE_RST;
      o_urgent <= `EEE_URGENT_RST;
      o_rdata  <= 32'h0;
    end else begin
      o_rdata <= 32'h0;
      if (i_wr) begin
        if (i_addr == `EEE_REG_ENABLE)
          o_enable <= i_wdata[9:0];
        for (p = 0; p < `EEE_NPORTS; p = p + 1) begin
          if (wr_idx == p[3:0])
            o_urgent[p*8 +: 8] <= i_wdata[7:0];
        end
      end
      if (i_rd) begin
        if (i_addr == `EEE_REG_ENABLE)
          o_rdata <= {22'h0, o_enable};
        else if (i_addr == `EEE_REG_POWERED)
          o_rdata <= {22'h0, i_powered};
        else if (i_addr == `EEE_REG_ALLOW)
          o_rdata <= {22'h0, i_allow};
        else begin
          for (p = 0; p < `EEE_NPORTS; p = p + 1) begin
            if (urg_idx(i_addr) == p[3:0])
              o_rdata <= {24'h0, o_urgent[p*8 +: 8]};
          end
        end
      end
    end
  end

endmodule // eee_reg_slave

`default_nettype wire

// ===== eee_lpi_tx_hold_control.v
// Per-port energy-saving transmit control: powers transmit circuits down when
// idle, defers wake-up by byte threshold or hold timer, urgent queues bypass.
// Assumes queue status and link resolution inputs are synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "eee_defines.vh"

module eee_lpi_tx_hold_control #(
  parameter WAKE_OTHER_CYC = `EEE_WAKE_OTHER_CYC,
  parameter HOLD_CYC       = `EEE_HOLD_CYC
) (
  input  wire         i_clk,
  input  wire         i_nrst,
  input  wire [7:0]   i_addr,
  input  wire [31:0]  i_wdata,
  input  wire         i_wr,
  input  wire         i_rd,
  output wire [31:0]  o_rdata,
  input  wire [9:0]   i_aneg,
  input  wire [9:0]   i_speed_1g,
  input  wire [9:0]   i_fdx_100m,
  input  wire [79:0]  i_q_nonempty,
  input  wire [159:0] i_enq_bytes,
  output wire [9:0]   o_tx_powered,
  output wire [9:0]   o_tx_allow
);

  localparam [3:0] ST_SLEEP  = 4'b0001;
  localparam [3:0] ST_HOLD   = 4'b0010;
  localparam [3:0] ST_WAKE   = 4'b0100;
  localparam [3:0] ST_ACTIVE = 4'b1000;

  // Integer cycle figures cut to the counter widths on purpose
  localparam integer WAKE_1G_I  = `EEE_WAKE_1G_CYC;
  localparam integer WAKE_OTH_I = WAKE_OTHER_CYC;
  localparam integer HOLD_LIM_I = HOLD_CYC;
  localparam [12:0]  WAKE_1G    = WAKE_1G_I[12:0];
  localparam [12:0]  WAKE_OTH   = WAKE_OTH_I[12:0];
  localparam [13:0]  HOLD_LIM   = HOLD_LIM_I[13:0];

  wire [9:0]  enable;
  wire [79:0] urgent;
  wire [9:0]  powered_q;
  wire [9:0]  allow_q;

  assign o_tx_powered = powered_q;
  assign o_tx_allow   = allow_q;

  eee_reg_slave u_regs (
    .i_clk     (i_clk),
    .i_nrst    (i_nrst),
    .i_addr    (i_addr),
    .i_wdata   (i_wdata),
    .i_wr      (i_wr),
    .i_rd      (i_rd),
    .i_powered (powered_q),
    .i_allow   (allow_q),
    .o_rdata   (o_rdata),
    .o_enable  (enable),
    .o_urgent  (urgent)
  );

  // Saturating byte accumulator
  function [15:0] sat_add;
    input [15:0] a;
    input [15:0] b;
    reg   [16:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[16] ? 16'hffff : s[15:0];
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `EEE_NPORTS; g = g + 1) begin : g_port
      reg  [3:0]  st_q;
      reg  [3:0]  st_d;
      reg  [13:0] hold_q;
      reg  [13:0] hold_d;
      reg  [15:0] bytes_q;
      reg  [15:0] bytes_d;
      reg  [12:0] wake_q;
      reg  [12:0] wake_d;
      reg         pwr_d;
      reg         alw_d;
      reg         pwr_q;
      reg         alw_q;

      // One flop per port, gathered into the status vectors
      assign powered_q[g] = pwr_q;
      assign allow_q[g]   = alw_q;

      wire [7:0]  qne     = i_q_nonempty[g*8 +: 8];
      wire        any_q   = |qne;
      wire        urg_hit = |(qne & urgent[g*8 +: 8]);
      wire [15:0] add     = i_enq_bytes[g*16 +: 16];
      // Eligible only when enabled and resolved to a saving-capable mode
      wire        elig    = enable[g] & i_aneg[g]
                            & (i_speed_1g[g] | i_fdx_100m[g]);
      // Link ends must agree on this figure; per-speed default used
      wire [12:0] wake_lim = i_speed_1g[g] ? WAKE_1G : WAKE_OTH;

      always @* begin
        st_d    = st_q;
        hold_d  = hold_q;
        bytes_d = bytes_q;
        wake_d  = wake_q;
        pwr_d   = 1'b1;
        alw_d   = 1'b0;
        if (!elig) begin
          // Ineligible ports stay fully powered
          st_d    = ST_ACTIVE;
          hold_d  = 14'h0;
          bytes_d = 16'h0;
          wake_d  = 13'h0;
          alw_d   = 1'b1;
        end else begin
          case (st_q)
            ST_SLEEP: begin
              pwr_d   = 1'b0;
              bytes_d = sat_add(bytes_q, add);
              if (urg_hit) begin
                st_d  = ST_WAKE;
                pwr_d = 1'b1;
              end else if (any_q) begin
                st_d   = ST_HOLD;
                hold_d = 14'h1;
              end
            end
            ST_HOLD: begin
              pwr_d   = 1'b0;
              bytes_d = sat_add(bytes_q, add);
              if (hold_q != 14'h3fff)
                hold_d = hold_q + 14'h1;
              if (urg_hit || bytes_d >= `EEE_BYTE_THRESH
                  || hold_q >= HOLD_LIM) begin
                st_d  = ST_WAKE;
                pwr_d = 1'b1;
              end
            end
            ST_WAKE: begin
              wake_d = wake_q + 13'h1;
              if (wake_d >= wake_lim) begin
                st_d  = ST_ACTIVE;
                alw_d = 1'b1;
              end
            end
            ST_ACTIVE: begin
              alw_d = 1'b1;
              if (!any_q) begin
                st_d    = ST_SLEEP;
                pwr_d   = 1'b0;
                alw_d   = 1'b0;
                hold_d  = 14'h0;
                bytes_d = 16'h0;
                wake_d  = 13'h0;
              end
            end
            default: begin
              st_d    = ST_ACTIVE;
              hold_d  = 14'h0;
              bytes_d = 16'h0;
              wake_d  = 13'h0;
              alw_d   = 1'b1;
            end
          endcase
        end
      end

      always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          st_q    <= ST_ACTIVE;
          hold_q  <= 14'h0;
          bytes_q <= 16'h0;
          wake_q  <= 13'h0;
          pwr_q   <= 1'b1;
          alw_q   <= 1'b1;
        end else begin
          st_q    <= st_d;
          hold_q  <= hold_d;
          bytes_q <= bytes_d;
          wake_q  <= wake_d;
          pwr_q   <= pwr_d;
          alw_q   <= alw_d;
        end
      end
    end
  endgenerate

endmodule // eee_lpi_tx_hold_control

`default_nettype wire

// ===== eee_hold_props.sv
// Checker for the energy-saving transmit control, watching ports 0 and 1.
// Assumes it is bound to the top module and mirrors the enable and port 0 urgent mask.
`timescale 1ns/1ps
`default_nettype none
module eee_hold_props #(
  parameter WAKE_OTHER_CYC = 6000,
  parameter HOLD_CYC       = 9600
) (
  input wire        i_clk,
  input wire        i_nrst,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wdata,
  input wire        i_wr,
  input wire        i_rd,
  input wire [31:0] o_rdata,
  input wire [9:0]  i_aneg,
  input wire [9:0]  i_speed_1g,
  input wire [9:0]  i_fdx_100m,
  input wire [79:0] i_q_nonempty,
  input wire [9:0]  o_tx_powered,
  input wire [9:0]  o_tx_allow
);
  reg  [9:0]  en_q;
  reg  [7:0]  urg_q;
  reg  [15:0] wcnt_q;
  reg  [15:0] hcnt_q;
  wire        elig = en_q[0] & i_aneg[0] & (i_speed_1g[0] | i_fdx_100m[0]);
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      en_q <= 10'h000;
      urg_q <= 8'h00;
      wcnt_q <= 16'h0000;
      hcnt_q <= 16'h0000;
    end else begin
      if (i_wr && i_addr == 8'h00) en_q <= i_wdata[9:0];
      if (i_wr && i_addr == 8'h10) urg_q <= i_wdata[7:0];
      // Cycles spent powered but not yet allowed
      wcnt_q <= !o_tx_powered[0] ? 16'h0000 : wcnt_q + {15'h0000, !o_tx_allow[0]};
      hcnt_q <= (!o_tx_powered[1] && i_q_nonempty[15:8] != 8'h00) ? hcnt_q + 16'h0001 : 16'h0000;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  chk_inelig_on: assert property (!elig |=> o_tx_powered[0] && o_tx_allow[0])
    else $error("ineligible port not powered");
  chk_allow_pwr: assert property ((o_tx_allow & ~o_tx_powered) == 10'h000)
    else $error("allow without power");
  chk_idle_sleep: assert property (
    elig && o_tx_allow[0] && i_q_nonempty[7:0] == 8'h00 |=> !o_tx_powered[0])
    else $error("idle port stayed powered");
  chk_wake_time: assert property (
    $rose(o_tx_allow[0]) && $past(elig)
    |-> wcnt_q == ($past(i_speed_1g[0]) ? 16'd3400 : WAKE_OTHER_CYC))
    else $error("wrong wakeup time");
  chk_urgent_wake: assert property (
    elig && !o_tx_powered[0] && (i_q_nonempty[7:0] & urg_q) != 8'h00 |=> o_tx_powered[0])
    else $error("urgent queue did not wake");
  chk_hold_bound: assert property (hcnt_q <= HOLD_CYC + 2)
    else $error("hold time exceeded");
  chk_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h00000000)
    else $error("read data outside read cycle");
  chk_rd_enable: assert property (
    $past(i_rd) && $past(i_addr) == 8'h00 |-> o_rdata == {22'h0, $past(en_q)})
    else $error("enable read wrong");
  cov_wake: cover property ($rose(o_tx_allow[0]));
  cov_hold: cover property ($rose(o_tx_powered[1]));
  cov_sleep: cover property ($fell(o_tx_powered[0]));
endmodule // eee_hold_props
bind eee_lpi_tx_hold_control eee_hold_props #(.WAKE_OTHER_CYC(WAKE_OTHER_CYC), .HOLD_CYC(HOLD_CYC))
  i_props (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_aneg(i_aneg), .i_speed_1g(i_speed_1g), .i_fdx_100m(i_fdx_100m),
  .i_q_nonempty(i_q_nonempty), .o_tx_powered(o_tx_powered), .o_tx_allow(o_tx_allow));
`default_nettype wire

// ===== eee_link_partner.sv
// Link partner model for one port: powers up with the port.
// Assumes the bench clock; flags frames allowed before its own wakeup time.
`timescale 1ns/1ps
`default_nettype none
module eee_link_partner #(parameter WAKE = 3400) (
  input  wire i_clk,
  input  wire i_nrst,
  input  wire i_powered,
  input  wire i_allow,
  input  wire i_eee,
  output reg  o_bad
);
  integer cnt;
  reg     al_q;
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt <= 0;
      al_q <= 1'b1;
      o_bad <= 1'b0;
    end else begin
      // Energy saving agreed off: link counts as always awake
      if (!i_eee) cnt <= WAKE;
      else cnt <= i_powered ? cnt + 1 : 0;
      al_q <= i_allow;
      if (i_allow && !al_q && cnt < WAKE) o_bad <= 1'b1;
    end
  end
endmodule // eee_link_partner
`default_nettype wire

// ===== tb.sv
// Self-checking bench for the energy-saving transmit control.
// Assumes short wake and hold parameters; port 0 gigabit, port 1 100M.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam WO = 20;
  localparam HC = 30;
  logic         i_clk, i_nrst, i_wr, i_rd;
  logic [7:0]   i_addr;
  logic [31:0]  i_wdata;
  logic [9:0]   i_aneg, i_speed_1g, i_fdx_100m;
  logic [79:0]  i_q_nonempty;
  logic [159:0] i_enq_bytes;
  wire  [31:0]  o_rdata;
  wire  [9:0]   o_tx_powered, o_tx_allow;
  wire          bad;
  logic         peer_eee;
  int           fail_count, comparisons, n, b;
  eee_lpi_tx_hold_control #(.WAKE_OTHER_CYC(WO), .HOLD_CYC(HC)) i_dut (.i_clk(i_clk),
    .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_aneg(i_aneg), .i_speed_1g(i_speed_1g), .i_fdx_100m(i_fdx_100m),
    .i_q_nonempty(i_q_nonempty), .i_enq_bytes(i_enq_bytes), .o_tx_powered(o_tx_powered),
    .o_tx_allow(o_tx_allow));
  eee_link_partner #(.WAKE(3400)) i_peer (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_powered(o_tx_powered[0]), .i_allow(o_tx_allow[0]), .i_eee(peer_eee), .o_bad(bad));
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  task final_report;
    if (fail_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", e, o_rdata);
  endtask
  // Bounded wait for power (al=0) or allow (al=1) of port p
  task wt(input int p, input bit al);
    n = 0;
    while ((al ? o_tx_allow[p] : o_tx_powered[p]) !== 1'b1) begin
      @(posedge i_clk);
      #1 n++;
      if (n > 5000) begin
        fail_count++;
        final_report();
      end
    end
  endtask
  task hold(input int by, input int lo, input int hi);
    @(posedge i_clk);
    i_q_nonempty[8] <= 1'b1;
    i_enq_bytes[31:16] <= by[15:0];
    wt(1, 0);
    chk("hold", 32'h1, {31'h0, n >= lo && n <= hi});
    wt(1, 1);
    chk("wake100", 32'(WO), 32'(n));
    @(posedge i_clk);
    i_q_nonempty[8] <= 1'b0;
    i_enq_bytes[31:16] <= 16'h0000;
    repeat (3) @(posedge i_clk);
  endtask
  initial begin
    i_nrst = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_aneg = 10'h3fb;
    i_speed_1g = 10'h001;
    i_fdx_100m = 10'h3f6;
    i_q_nonempty = 80'h0;
    i_enq_bytes = 160'h0;
    peer_eee = 1'b1;
    void'($urandom(32'h8c1f));
    repeat (4) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1 chk("pwr_rst", 32'h3ff, {22'h0, o_tx_powered});
    wr(8'h10, 32'h1);
    wr(8'h00, 32'h3ff);
    rd(8'h04, 32'h00c);
    rd(8'h08, 32'h00c);
    rd(8'h10, 32'h1);
    rd(8'h00, 32'h3ff);
    rd(8'hfc, 32'h0);
    @(posedge i_clk);
    i_q_nonempty[0] <= 1'b1;
    wt(0, 1);
    chk("wake1g", 32'd3401, 32'(n));
    @(posedge i_clk);
    i_q_nonempty[0] <= 1'b0;
    b = 500 + $urandom % 1000;
    hold(b, (2999 + b) / b, (2999 + b) / b + 1);
    hold(0, HC - 1, HC + 2);
    peer_eee <= 1'b0;
    wr(8'h00, 32'h3fe);
    repeat (2) @(posedge i_clk);
    #1 chk("inelig", 32'h3, {30'h0, o_tx_allow[0], o_tx_powered[0]});
    chk("peer", 32'h0, {31'h0, bad});
    final_report();
  end
endmodule // tb
`default_nettype wire
